// *** acd_i2c_slave.sv ***
// Purpose: I2C control and diagnostic interface of a four-channel amplifier
// Assumes: SCL and SDA oversampled by ref_clk; SCL far slower than ref_clk
// Notes: fault measurement is outside; its flags enter as inputs
`timescale 1ns/1ps
`default_nettype none
module acd_i2c_slave #(
    parameter int MUTE_NORMAL_CYC = 8000
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin level
    output logic sda_out, // bus data drive value
    output logic sda_oe, // high while driving SDA
    input wire acd_pkg::acd_chan_fault_t fault_lf, // live left-front flags
    input wire acd_pkg::acd_chan_fault_t fault_lr, // live left-rear flags
    input wire acd_pkg::acd_chan_fault_t fault_rf, // live right-front flags
    input wire acd_pkg::acd_chan_fault_t fault_rr, // live right-rear flags
    input wire logic offset_now, // output offset present now
    input wire logic thermal_155, // thermal warning 1
    input wire logic thermal_140, // thermal warning 2
    input wire logic thermal_120, // thermal warning 3
    input wire logic diag_cycle_done, // diagnostic cycle terminated
    output acd_pkg::acd_ctrl_t ctrl, // applied control fields
    output logic front_unmuted, // front mute stage released
    output logic rear_unmuted, // rear mute stage released
    output logic mute_busy, // a mute transition runs
    output logic diag_restart // pulse: restart diagnostic cycles
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_READ = 5'b01000,
        ST_IGNORE = 5'b10000
    } acd_state_t;

    logic scl_s, sda_s, scl_d_reg, sda_d_reg;
    logic scl_rise, scl_fall, start_det, stop_det;
    acd_state_t state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_reg;
    logic [2:0] byte_reg;
    logic ack_phase_reg;
    logic nack_reg;
    logic [7:0] pri_reg, sec_reg, pri_hold_reg;
    logic [7:0] diag_reg [0:3];
    logic ofs_persist_reg;
    logic fu_busy, ru_busy;

    acd_sync u_scl (.ref_clk(ref_clk), .rst(rst), .pin_in(scl_in), .pin_sync(scl_s));
    acd_sync u_sda (.ref_clk(ref_clk), .rst(rst), .pin_in(sda_in), .pin_sync(sda_s));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // diagnostic byte assembly: two status bits above the six channel fault flags
    function automatic logic [7:0] chan_byte(input logic b7, input logic b6,
                                              input acd_pkg::acd_chan_fault_t f);
        chan_byte = {b7, b6, f};
    endfunction

    // live diagnostic bytes; all four are captured together at a read so that
    // the first byte sent belongs to the same window as the other three
    logic [7:0] diag_now [0:3];
    always_comb begin
        diag_now[0] = chan_byte(thermal_155, diag_cycle_done,
            fault_lf | {3'h0, ofs_persist_reg & ctrl.offset_en & offset_now, 2'h0});
        diag_now[1] = chan_byte(ctrl.offset_en, 1'b0, fault_lr);
        diag_now[2] = chan_byte(ctrl.operate, ctrl.diag_en, fault_rf);
        diag_now[3] = chan_byte(thermal_140, thermal_120, fault_rr);
    end

    // transfer sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 4'h0;
            byte_reg <= 3'h0;
            ack_phase_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= ST_ADDR;
            bit_reg <= 4'h0;
            byte_reg <= 3'h0;
            ack_phase_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            ack_phase_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // bus idle: keep the bit machinery parked
                    bit_reg <= 4'h0;
                    ack_phase_reg <= 1'b0;
                end
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise && !ack_phase_reg) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        if (state_reg == ST_ADDR && shift_reg[7:1] != acd_pkg::DEV_ADDR) begin
                            state_reg <= ST_IGNORE;
                        end else if (state_reg == ST_WRITE && byte_reg >= 3'(acd_pkg::CTRL_BYTES)) begin
                            state_reg <= ST_IGNORE;
                        end else begin
                            ack_phase_reg <= 1'b1;
                        end
                    end else if (scl_fall && ack_phase_reg) begin
                        ack_phase_reg <= 1'b0;
                        if (state_reg == ST_ADDR) begin
                            state_reg <= shift_reg[0] ? ST_READ : ST_WRITE;
                            shift_reg <= diag_now[0];
                            byte_reg <= 3'h0;
                        end else begin
                            byte_reg <= byte_reg + 3'h1;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall && !ack_phase_reg && bit_reg != 4'h8) begin
                        if (bit_reg == 4'h7) begin
                            bit_reg <= 4'h8;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            bit_reg <= bit_reg + 4'h1;
                        end
                    end else if (bit_reg == 4'h8 && !ack_phase_reg) begin
                        ack_phase_reg <= 1'b1;
                    end else if (ack_phase_reg && scl_rise) begin
                        nack_reg <= sda_s;
                    end else if (ack_phase_reg && scl_fall) begin
                        ack_phase_reg <= 1'b0;
                        bit_reg <= 4'h0;
                        if (nack_reg || byte_reg == 3'(acd_pkg::DIAG_BYTES - 1)) begin
                            state_reg <= ST_IGNORE;
                        end else begin
                            byte_reg <= byte_reg + 3'h1;
                            shift_reg <= diag_reg[byte_reg[1:0] + 2'h1];
                        end
                    end
                end
                ST_IGNORE: begin
                    ack_phase_reg <= 1'b0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // SDA drive: acknowledge in write, data bits in read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end else if (scl_fall || start_det || stop_det) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (!scl_s) begin
            if ((state_reg == ST_ADDR || state_reg == ST_WRITE) && ack_phase_reg) begin
                sda_out <= 1'b0;
                sda_oe <= 1'b1;
            end else if (state_reg == ST_READ && !ack_phase_reg && bit_reg != 4'h8) begin
                sda_out <= shift_reg[7];
                sda_oe <= ~shift_reg[7];
            end
        end
    end

    // instruction byte capture; applied at the end of the second byte of a write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pri_hold_reg <= acd_pkg::PRI_RESET;
            pri_reg <= acd_pkg::PRI_RESET;
            sec_reg <= acd_pkg::SEC_RESET;
        end else if (state_reg == ST_WRITE && scl_fall && bit_reg == 4'h8) begin
            if (byte_reg == 3'h0) begin
                pri_hold_reg <= shift_reg;
            end else if (byte_reg == 3'h1) begin
                pri_reg <= pri_hold_reg;
                sec_reg <= shift_reg;
            end
        end
    end

    assign ctrl.diag_en = pri_reg[acd_pkg::PRI_DIAG_EN];
    assign ctrl.offset_en = pri_reg[acd_pkg::PRI_OFS_EN];
    assign ctrl.front_gain_12db = pri_reg[acd_pkg::PRI_FRONT_GAIN];
    assign ctrl.rear_gain_12db = pri_reg[acd_pkg::PRI_REAR_GAIN];
    assign ctrl.front_unmute = pri_reg[acd_pkg::PRI_FRONT_UNMUTE];
    assign ctrl.rear_unmute = pri_reg[acd_pkg::PRI_REAR_UNMUTE];
    assign ctrl.clip_thr_10pct = pri_reg[acd_pkg::PRI_CLIP_THR];
    assign ctrl.fast_mute = sec_reg[acd_pkg::SEC_FAST_MUTE];
    assign ctrl.operate = sec_reg[acd_pkg::SEC_OPERATE];
    assign ctrl.line_driver_diag = sec_reg[acd_pkg::SEC_LINE_DRV];
    assign ctrl.current_det_en = sec_reg[acd_pkg::SEC_CUR_DET];
    assign ctrl.high_eff_right = sec_reg[acd_pkg::SEC_HE_RIGHT];
    assign ctrl.high_eff_left = sec_reg[acd_pkg::SEC_HE_LEFT];

    acd_mute_timer #(.NORMAL_CYC(MUTE_NORMAL_CYC)) u_front (
        .ref_clk(ref_clk), .rst(rst),
        .unmute_req(ctrl.front_unmute & ctrl.operate),
        .fast(ctrl.fast_mute), .unmuted(front_unmuted), .busy(fu_busy));
    acd_mute_timer #(.NORMAL_CYC(MUTE_NORMAL_CYC)) u_rear (
        .ref_clk(ref_clk), .rst(rst),
        .unmute_req(ctrl.rear_unmute & ctrl.operate),
        .fast(ctrl.fast_mute), .unmuted(rear_unmuted), .busy(ru_busy));
    assign mute_busy = fu_busy | ru_busy;

    // offset window: opened by the last read or by enabling, closed at this read
    logic ofs_en_d_reg, read_end;
    assign read_end = (state_reg == ST_ADDR) && scl_fall && ack_phase_reg && shift_reg[0];
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ofs_en_d_reg <= 1'b0;
            ofs_persist_reg <= 1'b0;
        end else begin
            ofs_en_d_reg <= ctrl.offset_en;
            if (read_end || (ctrl.offset_en && !ofs_en_d_reg)) begin
                ofs_persist_reg <= 1'b1;
            end else if (!offset_now) begin
                ofs_persist_reg <= 1'b0;
            end
        end
    end

    // snapshot of diagnostic data taken at each read; restart pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < acd_pkg::DIAG_BYTES; i++) begin
                diag_reg[i] <= 8'h00;
            end
            diag_restart <= 1'b0;
        end else begin
            diag_restart <= read_end;
            if (read_end) begin
                for (int i = 0; i < acd_pkg::DIAG_BYTES; i++) begin
                    diag_reg[i] <= diag_now[i];
                end
            end
        end
    end
endmodule // acd_i2c_slave
`default_nettype wire

// *** acd_pkg.sv ***
// Purpose: shared constants and types of the amplifier control interface
// Assumes: ref_clk at 40 MHz
// Notes: bit positions of the control and diagnostic bytes
`default_nettype none
package acd_pkg;
    localparam int CLK_HZ = 40000000;
    localparam logic [6:0] DEV_ADDR = 7'h6C;
    localparam int CTRL_BYTES = 2;
    localparam int DIAG_BYTES = 4;
    localparam int FAST_MUTE_US = 1500;
    localparam int FAST_MUTE_CYC = (CLK_HZ / 1000) * FAST_MUTE_US / 1000;
    localparam logic [7:0] PRI_RESET = 8'h00;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam int PRI_DIAG_EN = 6;
    localparam int PRI_OFS_EN = 5;
    localparam int PRI_FRONT_GAIN = 4;
    localparam int PRI_REAR_GAIN = 3;
    localparam int PRI_FRONT_UNMUTE = 2;
    localparam int PRI_REAR_UNMUTE = 1;
    localparam int PRI_CLIP_THR = 0;
    localparam int SEC_FAST_MUTE = 5;
    localparam int SEC_OPERATE = 4;
    localparam int SEC_LINE_DRV = 3;
    localparam int SEC_CUR_DET = 2;
    localparam int SEC_HE_RIGHT = 1;
    localparam int SEC_HE_LEFT = 0;

    typedef struct packed {
        logic low_current;
        logic permanent;
        logic short_load;
        logic open_or_offset;
        logic short_supply;
        logic short_ground;
    } acd_chan_fault_t;

    typedef struct packed {
        logic diag_en;
        logic offset_en;
        logic front_gain_12db;
        logic rear_gain_12db;
        logic front_unmute;
        logic rear_unmute;
        logic clip_thr_10pct;
        logic fast_mute;
        logic operate;
        logic line_driver_diag;
        logic current_det_en;
        logic high_eff_right;
        logic high_eff_left;
    } acd_ctrl_t;
endpackage
`default_nettype wire

// *** acd_sync.sv ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: single clock ref_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module acd_sync (
    input wire logic ref_clk, // clock
    input wire logic rst, // async reset
    input wire logic pin_in, // asynchronous input
    output logic pin_sync // synchronised level
);
    logic stage1_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            stage1_reg <= pin_in;
            pin_sync <= stage1_reg;
        end
    end
endmodule // acd_sync
`default_nettype wire

// *** acd_mute_timer.sv ***
// Purpose: mute transition timer, normal or fast
// Assumes: normal time given by parameter
// Notes: busy while a mute change is in progress
`timescale 1ns/1ps
`default_nettype none
module acd_mute_timer #(
    parameter int NORMAL_CYC = 8000
) (
    input wire logic ref_clk, // clock
    input wire logic rst, // async reset
    input wire logic unmute_req, // requested unmute level
    input wire logic fast, // fast mute selected
    output logic unmuted, // applied unmute level
    output logic busy // transition running
);
    logic [31:0] cnt_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 32'h0;
            unmuted <= 1'b0;
            busy <= 1'b0;
        end else if (busy) begin
            if (cnt_reg <= 32'h1) begin
                busy <= 1'b0;
                unmuted <= unmute_req;
            end else begin
                cnt_reg <= cnt_reg - 32'h1;
            end
        end else if (unmute_req != unmuted) begin
            busy <= 1'b1;
            if (fast) begin
                cnt_reg <= 32'(acd_pkg::FAST_MUTE_CYC - 1);
            end else begin
                cnt_reg <= 32'(NORMAL_CYC);
            end
        end
    end
endmodule // acd_mute_timer
`default_nettype wire

// *** acd_i2c_checker.sv ***
// Purpose: bus drive and mute timing checks of the control slave
// Assumes: scl_in far slower than ref_clk
// Notes: bound to every acd_i2c_slave
`timescale 1ns/1ps
`default_nettype none
module acd_i2c_checker #(
    parameter int MUTE_NORMAL_CYC = 8000
) (
    input wire logic ref_clk, // clock
    input wire logic rst, // async reset
    input wire logic scl_in, // bus clock pin
    input wire logic sda_out, // data drive value
    input wire logic sda_oe, // data drive enable
    input wire acd_pkg::acd_ctrl_t ctrl, // applied controls
    input wire logic front_unmuted, // front stage released
    input wire logic mute_busy, // mute transition runs
    input wire logic diag_restart // restart pulse
);
    localparam logic [16:0] NORM_LIM = 17'(MUTE_NORMAL_CYC + 2);
    logic [16:0] busy_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // length of the running mute transition
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_cnt <= 17'h00000;
        end else begin
            busy_cnt <= mute_busy ? busy_cnt + 17'h00001 : 17'h00000;
        end
    end
    sequence s_drive_held;
        sda_oe [*8];
    endsequence
    sequence s_near_ack;
        ##[0:4] sda_oe;
    endsequence
    property p_oe_low; sda_oe |-> !sda_out; endproperty
    property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
    property p_oe_held; $rose(sda_oe) |-> s_drive_held; endproperty
    property p_ctrl_at_ack; $changed(ctrl) |-> s_near_ack; endproperty
    property p_restart_pulse; diag_restart |=> !diag_restart; endproperty
    property p_restart_scl_low; diag_restart |-> !scl_in; endproperty
    property p_mute_len; busy_cnt <= (ctrl.fast_mute ? 17'h0EA5F : NORM_LIM); endproperty
    property p_unmute_busy; $changed(front_unmuted) |-> mute_busy || $past(mute_busy); endproperty
    a_oe_low: assert property (p_oe_low) else $error("sda driven high");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda changed with scl high");
    a_oe_held: assert property (p_oe_held) else $error("sda drive too short");
    a_ctrl_at_ack: assert property (p_ctrl_at_ack) else $error("ctrl changed off ack");
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse too long");
    a_restart_scl_low: assert property (p_restart_scl_low) else $error("restart off ack end");
    a_mute_len: assert property (p_mute_len) else $error("mute transition too long");
    a_unmute_busy: assert property (p_unmute_busy) else $error("unmute moved while idle");
endmodule // acd_i2c_checker
bind acd_i2c_slave acd_i2c_checker #(.MUTE_NORMAL_CYC(MUTE_NORMAL_CYC)) u_acd_i2c_checker (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl),
    .front_unmuted(front_unmuted), .mute_busy(mute_busy), .diag_restart(diag_restart));
`default_nettype wire

// *** acd_host_model.sv ***
// Purpose: behavioural host that masters the two-wire control bus
// Assumes: sda pulled up; host only pulls sda low, drives scl both ways
// Notes: scl half period is ten device clocks
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
    output logic scl, // bus clock
    output logic sda_low, // high while host pulls sda low
    input wire logic sda // resolved sda level
);
    localparam time Q = 125ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit slot: data set mid-low, sampled mid-high
    task automatic slot(input logic b, output logic r);
        scl = 1'b0;
        #Q sda_low = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q;
    endtask
    task automatic start();
        scl = 1'b0;
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #(2*Q) sda_low = 1'b1;
        #(2*Q);
    endtask
    task automatic stop();
        scl = 1'b0;
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #(2*Q) sda_low = 1'b0;
        #(2*Q);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            slot(d[i], q[i]);
        end
        slot(ack_in, ack);
    endtask
endmodule // acd_host_model
`default_nettype wire

// *** acd_i2c_slave_tb_top.sv ***
// Purpose: self-checking bench of the amplifier control slave
// Assumes: normal mute time shortened to 20 cycles
// Notes: host model masters the bus; fault flags driven here
`timescale 1ns/1ps
`default_nettype none
module acd_i2c_slave_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, host_low, sda, sda_out, sda_oe;
    logic offset_now = 1'b0;
    logic t155 = 1'b0, t140 = 1'b0, t120 = 1'b0, cyc_done = 1'b0;
    logic front_unmuted, rear_unmuted, mute_busy, diag_restart;
    acd_pkg::acd_chan_fault_t f_lf = 6'h00, f_lr = 6'h00, f_rf = 6'h00, f_rr = 6'h00;
    acd_pkg::acd_ctrl_t ctrl;
    int fail_count = 0;
    int samples_checked = 0;
    int restarts = 0;
    assign sda = !(host_low || (sda_oe && !sda_out));
    always #12.5ns ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (diag_restart === 1'b1) restarts++;
    end
    acd_i2c_slave #(.MUTE_NORMAL_CYC(20)) u_acd_i2c_slave (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .fault_lf(f_lf), .fault_lr(f_lr), .fault_rf(f_rf), .fault_rr(f_rr), .offset_now(offset_now),
        .thermal_155(t155), .thermal_140(t140), .thermal_120(t120), .diag_cycle_done(cyc_done),
        .ctrl(ctrl), .front_unmuted(front_unmuted), .rear_unmuted(rear_unmuted), .mute_busy(mute_busy),
        .diag_restart(diag_restart));
    acd_host_model u_acd_host_model (.scl(scl), .sda_low(host_low), .sda(sda));
    task automatic chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_ctrl(input string n, input acd_pkg::acd_ctrl_t e, input acd_pkg::acd_ctrl_t g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic host_write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] s,
                              input logic more, output logic [2:0] k);
        logic [7:0] q;
        u_acd_host_model.start();
        u_acd_host_model.xfer(a, 1'b1, q, k[2]);
        u_acd_host_model.xfer(p, 1'b1, q, k[1]);
        u_acd_host_model.xfer(s, 1'b1, q, k[0]);
        if (!more) u_acd_host_model.stop();
    endtask
    task automatic host_read(output logic [31:0] d, output logic a);
        logic [7:0] q;
        logic x;
        u_acd_host_model.start();
        u_acd_host_model.xfer(8'hD9, 1'b1, q, a);
        for (int j = 0; j < 4; j++) begin
            u_acd_host_model.xfer(8'hFF, j == 3, d[31-8*j -: 8], x);
        end
        u_acd_host_model.stop();
    endtask
    task automatic t_reset();
        chk_bit("sda_oe", 1'b0, sda_oe);
        chk_ctrl("ctrl", 13'h0000, ctrl);
        chk_bit("front_unmuted", 1'b0, front_unmuted);
        chk_bit("diag_restart", 1'b0, diag_restart);
        $display("test reset done");
    endtask
    task automatic t_write();
        logic [15:0] tab [3] = '{16'h2A1A, 16'h5515, 16'h0000};
        logic [2:0] k;
        foreach (tab[i]) begin
            host_write(8'hD8, tab[i][15:8], tab[i][7:0], 1'b0, k);
            chk_byte("write acks", 8'h00, {5'h00, k});
            chk_ctrl("ctrl", {tab[i][14:8], tab[i][5:0]}, ctrl);
            repeat (100) @(negedge ref_clk);
            if (tab[i][4] === 1'b1) begin
                chk_bit("front_unmuted", tab[i][10], front_unmuted);
                chk_bit("rear_unmuted", tab[i][9], rear_unmuted);
            end
        end
        $display("test write done");
    endtask
    task automatic t_refuse();
        logic [7:0] q;
        logic [2:0] k;
        logic n;
        host_write(8'hDA, 8'h7F, 8'h1F, 1'b0, k);
        chk_bit("foreign ack", 1'b1, k[2]);
        chk_ctrl("ctrl", 13'h0000, ctrl);
        host_write(8'hD8, 8'h55, 8'h15, 1'b1, k);
        u_acd_host_model.xfer(8'h00, 1'b1, q, n);
        u_acd_host_model.stop();
        chk_bit("third byte ack", 1'b1, n);
        chk_ctrl("ctrl", {7'h55, 6'h15}, ctrl);
        $display("test refuse done");
    endtask
    task automatic t_read();
        logic [31:0] d;
        logic [31:0] e;
        logic a;
        int r0;
        for (int k = 0; k < 2; k++) begin
            @(negedge ref_clk);
            f_lf = (k == 1) ? 6'h15 : 6'h2A;
            f_lr = (k == 1) ? 6'h2A : 6'h15;
            f_rf = (k == 1) ? 6'h0C : 6'h33;
            f_rr = (k == 1) ? 6'h33 : 6'h0C;
            {t155, cyc_done, t140, t120} = (k == 1) ? 4'h2 : 4'hD;
            e = {t155, cyc_done, f_lf, 2'h0, f_lr, 2'h3, f_rf, t140, t120, f_rr};
            r0 = restarts;
            for (int r = 0; r < 2; r++) begin
                host_read(d, a);
                chk_bit("read ack", 1'b0, a);
                for (int j = 0; j < 4; j++) begin
                    chk_byte("diag byte", e[31-8*j -: 8], d[31-8*j -: 8]);
                end
            end
            chk_bit("restarts", 1'b1, (restarts - r0) == 2);
        end
        $display("test read done");
    endtask
    task automatic t_fast();
        logic [2:0] k;
        int n = 0;
        host_write(8'hD8, 8'h46, 8'h10, 1'b0, k);
        repeat (100) @(negedge ref_clk);
        host_write(8'hD8, 8'h40, 8'h30, 1'b0, k);
        while (mute_busy !== 1'b0 && n < 70000) begin
            @(negedge ref_clk);
            n++;
        end
        chk_bit("front_unmuted", 1'b0, front_unmuted);
        chk_bit("fast mute in time", 1'b1, n < 59999);
        host_write(8'hD8, 8'h00, 8'h00, 1'b0, k);
        chk_ctrl("ctrl", 13'h0000, ctrl);
        $display("test fast mute done");
    endtask
    task automatic t_offset();
        logic [31:0] d;
        logic [2:0] k;
        logic a;
        @(negedge ref_clk);
        {f_lf, f_lr, f_rf, f_rr} = 24'h000000;
        offset_now = 1'b1;
        host_write(8'hD8, 8'h20, 8'h10, 1'b0, k);
        repeat (40) @(negedge ref_clk);
        host_read(d, a);
        chk_bit("offset flag", 1'b1, d[26]);
        chk_bit("offset active", 1'b1, d[23]);
        offset_now = 1'b0;
        repeat (4) @(negedge ref_clk);
        offset_now = 1'b1;
        host_read(d, a);
        chk_bit("offset flag", 1'b0, d[26]);
        $display("test offset done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_reset();
        t_write();
        t_refuse();
        t_read();
        t_fast();
        t_offset();
        complete_run();
    end
    // hang guard: the whole run needs under 2 ms
    initial begin
        #2400us;
        fail_count++;
        complete_run();
    end
endmodule // acd_i2c_slave_tb_top
`default_nettype wire
